/* File: ssc_core.v */
// Contract
// - Sync starts only with request during servo-on
// - Gear ratio outside 1/16000..6000 faults start
// - Request during gear reload faults start
// - Sync acceleration above 20000 ms faults start
// - Sync deceleration above 20000 ms faults start
// - Communication reset while running faults, stops
// - Home latched at power-on or communication reset
// - Superimposed starts when request follows command
// - Command without request raises superimposed error
// - Zero feed speed raises superimposed error
// - Out-of-range superimposed settings raise warning
// - Alarm or link loss stops superimposed control
// - Superimposed move completes despite command drop
// - Request drop ramps down with sync deceleration
// - Travel limit keeps home, drops synchronisation
// - New gear values apply only after reload done
// - Fault flag is one bit: one means error
//
// Purpose: Sequencer for synchronous and superimposed synchronous control
// Assumes: Inputs synchronous to clk; settings are plain parallel words
// Notes:   Gear reload done follows request by two cycles in this model
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.vh"

module ssc_core #(
  parameter W         = 32,
  parameter MS_CYCLES = `SSC_MS_CYCLES
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Command bits from the controller
  input  wire         servo_on,
  input  wire         sync_run_request,
  input  wire         superimposed_cmd,
  input  wire         gear_reload_request,
  input  wire         comm_reset,
  input  wire         link_lost,
  input  wire         alarm,
  input  wire         forward_travel_limit,
  input  wire         reverse_travel_limit,
  // Setting objects
  input  wire [W-1:0] gear_num,
  input  wire [W-1:0] gear_den,
  input  wire [W-1:0] sync_accel_time,
  input  wire [W-1:0] sync_decel_time,
  input  wire [W-1:0] superimposed_accel_time,
  input  wire [W-1:0] superimposed_decel_time,
  input  wire [W-1:0] superimposed_feed_speed,
  input  wire [W-1:0] superimposed_feed_length,
  input  wire [W-1:0] speed_limit,
  input  wire [W-1:0] encoder_speed,
  input  wire [W-1:0] encoder_pos,
  // Status
  output reg          gear_reload_done,
  output reg          sync_fault_flag,
  output reg          superimposed_fault_flag,
  output reg          positioning_limit_warning,
  output reg          sync_running,
  output reg          synchronized,
  output reg          superimposed_busy,
  output reg  [W-1:0] home_pos_q,
  output reg  [W-1:0] motor_speed
);

  localparam [2:0] ST_IDLE   = `SSC_ST_IDLE;
  localparam [2:0] ST_RUN    = `SSC_ST_RUN;
  localparam [2:0] ST_STOP   = `SSC_ST_STOP;
  localparam [2:0] ST_FAULT  = `SSC_ST_FAULT;
  localparam [2:0] ST_UNSYNC = `SSC_ST_UNSYNC;

  // Gear ratio within 1/16000 .. 6000, widened so products never wrap
  function gear_ok;
    input [W-1:0] num;
    input [W-1:0] den;
    reg   [2*W-1:0] n16k;
    reg   [2*W-1:0] d6k;
    begin
      n16k    = num * `SSC_GEAR_MIN_DEN_MULT;
      d6k     = den * `SSC_GEAR_MAX_NUM_MULT;
      gear_ok = (den != {W{1'b0}}) && (n16k >= {{W{1'b0}}, den})
                && ({{W{1'b0}}, num} <= d6k);
    end
  endfunction

  // Per-tick step so full speed is reached in tc milliseconds
  function [W-1:0] ramp_step;
    input [W-1:0] full;
    input [W-1:0] tc;
    begin
      if (tc == {W{1'b0}}) begin
        ramp_step = full;
      end else begin
        ramp_step = (full / tc == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : full / tc;
      end
    end
  endfunction

  reg [2:0]   state_q;
  reg [2:0]   state_d;
  reg [W-1:0] act_num_q;
  reg [W-1:0] act_den_q;
  reg         reload_pend_q;
  reg         req_prev_q;
  reg         home_valid_q;
  reg [W-1:0] acc_tc_q;
  reg [W-1:0] dec_tc_q;
  reg [W-1:0] sup_left_q;
  reg [31:0]  ms_cnt_q;
  reg         tick_q;
  reg         cmd_prev_q;
  reg         fault_d;
  reg         ramp_load;
  reg [W-1:0] ramp_target;
  reg [W-1:0] ramp_step_v;
  wire [W-1:0] ramp_speed;
  wire         ramp_done;
  wire         req_rise;
  wire         start_bad;
  wire         stop_cause;

  assign req_rise   = sync_run_request && !req_prev_q;
  // Start checks on the gear, reload window and both time constants
  assign start_bad  = !gear_ok(act_num_q, act_den_q)
                      || reload_pend_q || gear_reload_request
                      || (sync_accel_time > `SSC_SYNC_TC_MAX_MS)
                      || (sync_decel_time > `SSC_SYNC_TC_MAX_MS);
  assign stop_cause = alarm || link_lost;

  // Millisecond tick divider paces the ramps
  always @(posedge clk) begin
    if (reset) begin
      ms_cnt_q <= 32'h00000000;
      tick_q   <= 1'b0;
    end else if (ms_cnt_q == MS_CYCLES - 1) begin
      ms_cnt_q <= 32'h00000000;
      tick_q   <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h00000001;
      tick_q   <= 1'b0;
    end
  end

  // Gear values are shadowed and applied only when reload completes
  always @(posedge clk) begin
    if (reset) begin
      act_num_q        <= 32'h00000001;
      act_den_q        <= 32'h00000001;
      reload_pend_q    <= 1'b0;
      gear_reload_done <= 1'b0;
    end else begin
      gear_reload_done <= 1'b0;
      if (gear_reload_request && !reload_pend_q) begin
        reload_pend_q <= 1'b1;
      end else if (reload_pend_q) begin
        act_num_q        <= gear_num;
        act_den_q        <= gear_den;
        reload_pend_q    <= 1'b0;
        gear_reload_done <= 1'b1;
      end
    end
  end

  // Main control sequence
  always @* begin
    state_d     = state_q;
    fault_d     = sync_fault_flag;
    ramp_load   = 1'b0;
    ramp_target = encoder_speed;
    ramp_step_v = ramp_step(speed_limit, acc_tc_q);
    case (state_q)
      ST_IDLE: begin
        ramp_target = {W{1'b0}};
        if (req_rise && servo_on) begin
          if (start_bad) begin
            state_d = ST_FAULT;
            fault_d = 1'b1;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (comm_reset) begin
          state_d = ST_FAULT;
          fault_d = 1'b1;
        end else if (!forward_travel_limit || !reverse_travel_limit) begin
          state_d = ST_UNSYNC;
        end else if (stop_cause || !servo_on) begin
          // Ramp down from this cycle so the speed never steps up on the way out
          state_d     = ST_STOP;
          ramp_target = {W{1'b0}};
          ramp_step_v = ramp_step(speed_limit, dec_tc_q);
        end else if (!sync_run_request) begin
          state_d     = ST_STOP;
          ramp_target = {W{1'b0}};
          ramp_step_v = ramp_step(speed_limit, dec_tc_q);
        end
      end
      ST_STOP: begin
        ramp_target = {W{1'b0}};
        ramp_step_v = ramp_step(speed_limit, dec_tc_q);
        // The done flag already refers to the zero target set on leaving run; the speed itself must reach zero
        if (ramp_done && (ramp_speed == {W{1'b0}})) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        ramp_target = {W{1'b0}};
        ramp_load   = 1'b1;
        if (!sync_run_request) begin
          state_d = ST_IDLE;
          fault_d = 1'b0;
        end
      end
      ST_UNSYNC: begin
        // Held off the encoder until the request is dropped for recovery
        ramp_target = {W{1'b0}};
        ramp_step_v = ramp_step(speed_limit, dec_tc_q);
        if (!sync_run_request && ramp_done && (ramp_speed == {W{1'b0}})) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ssc_ramp #(
    .W(W)
  ) u_ramp (
    .clk         (clk),
    .reset       (reset),
    .tick        (tick_q),
    .load        (ramp_load),
    .load_val    ({W{1'b0}}),
    .target      (ramp_target),
    .step        (ramp_step_v),
    .speed_q     (ramp_speed),
    .at_target_q (ramp_done)
  );

  // State, latched time constants and status outputs
  always @(posedge clk) begin
    if (reset) begin
      state_q         <= ST_IDLE;
      sync_fault_flag <= 1'b0;
      req_prev_q      <= 1'b0;
      acc_tc_q        <= 32'h00000000;
      dec_tc_q        <= 32'h00000000;
      sync_running    <= 1'b0;
      synchronized    <= 1'b0;
      motor_speed     <= `SSC_SPEED_RST;
    end else begin
      state_q         <= state_d;
      sync_fault_flag <= fault_d;
      req_prev_q      <= sync_run_request;
      if (state_q == ST_IDLE && state_d == ST_RUN) begin
        acc_tc_q <= sync_accel_time;  // Values at start are the ones used
        dec_tc_q <= sync_decel_time;
      end
      sync_running <= (state_d == ST_RUN) || (state_d == ST_STOP);
      synchronized <= (state_d == ST_RUN) && (state_q == ST_RUN)
                      && (ramp_speed == encoder_speed);
      motor_speed  <= ramp_speed;
    end
  end

  // Home follows power-on and communication reset; limits never clear it
  always @(posedge clk) begin
    if (reset) begin
      home_pos_q   <= `SSC_POS_RST;
      home_valid_q <= 1'b0;
    end else if (!home_valid_q || comm_reset) begin
      home_pos_q   <= encoder_pos;
      home_valid_q <= 1'b1;
    end
  end

  // Superimposed move: armed when the request rises with the command on
  always @(posedge clk) begin
    if (reset) begin
      superimposed_busy         <= 1'b0;
      superimposed_fault_flag   <= 1'b0;
      positioning_limit_warning <= 1'b0;
      sup_left_q                <= 32'h00000000;
      cmd_prev_q                <= 1'b0;
    end else begin
      cmd_prev_q <= superimposed_cmd;
      if (superimposed_cmd && !cmd_prev_q) begin
        // Settings outside their ranges warn but do not block
        positioning_limit_warning <= (superimposed_feed_speed > speed_limit)
          || (superimposed_accel_time > `SSC_SUP_TC_MAX_MS)
          || (superimposed_decel_time > `SSC_SUP_TC_MAX_MS);
        if (!sync_run_request) begin
          superimposed_fault_flag <= 1'b1;
        end
      end
      if (superimposed_busy) begin
        // Command drop is ignored; stop causes or leaving run end the move early
        if (stop_cause || state_q != ST_RUN) begin
          superimposed_busy <= 1'b0;
        end else if (tick_q) begin
          if (sup_left_q > superimposed_feed_speed) begin
            sup_left_q <= sup_left_q - superimposed_feed_speed;
          end else begin
            sup_left_q        <= 32'h00000000;
            superimposed_busy <= 1'b0;
          end
        end
      end else if (req_rise && superimposed_cmd && servo_on && home_valid_q) begin
        if (superimposed_feed_speed == {W{1'b0}}) begin
          superimposed_fault_flag <= 1'b1;
        end else if (!start_bad) begin
          superimposed_busy       <= 1'b1;
          superimposed_fault_flag <= 1'b0;
          sup_left_q              <= superimposed_feed_length;
        end
      end else if (!superimposed_cmd && !sync_run_request) begin
        superimposed_fault_flag <= 1'b0;
      end
    end
  end

endmodule // ssc_core

`default_nettype wire

/* File: ssc_defs.vh */
// Purpose: Constants for the superimposed synchronous control sequencer
// Assumes: Included by its bare name; definitions only
// Notes:   Gear limits compare num*16000 >= den and num <= den*6000
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// Gear ratio limits, as multipliers
`define SSC_GEAR_MIN_DEN_MULT 32'd16000
`define SSC_GEAR_MAX_NUM_MULT 32'd6000
// Largest legal time constants, in ms
`define SSC_SYNC_TC_MAX_MS    32'd20000
`define SSC_SUP_TC_MAX_MS     32'd20000
// Clock rate and millisecond tick
`define SSC_CLK_HZ            200000000
`define SSC_MS_CYCLES         (`SSC_CLK_HZ / 1000)
// Reset values
`define SSC_SPEED_RST         32'h00000000
`define SSC_POS_RST           32'h00000000
// Control states
`define SSC_ST_IDLE           3'h0
`define SSC_ST_RUN            3'h1
`define SSC_ST_STOP           3'h2
`define SSC_ST_FAULT          3'h3
`define SSC_ST_UNSYNC         3'h4

`endif

/* File: ssc_ramp.v */
// Purpose: Speed ramp that steps toward a target once per millisecond tick
// Assumes: Step size is precomputed by the caller from a time constant
// Notes:   Output is registered; reaches target exactly without overshoot
`timescale 1ns/1ps
`default_nettype none

module ssc_ramp #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Control
  input  wire         tick,
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire [W-1:0] target,
  input  wire [W-1:0] step,
  // Result
  output reg  [W-1:0] speed_q,
  output reg          at_target_q
);

  reg [W-1:0] speed_d;

  // Step up or down, clamping at the target
  always @* begin
    speed_d = speed_q;
    if (load) begin
      speed_d = load_val;
    end else if (tick) begin
      if (speed_q < target) begin
        speed_d = (target - speed_q > step) ? speed_q + step : target;
      end else if (speed_q > target) begin
        speed_d = (speed_q - target > step) ? speed_q - step : target;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      speed_q     <= {W{1'b0}};
      at_target_q <= 1'b1;
    end else begin
      speed_q     <= speed_d;
      at_target_q <= (speed_d == target);
    end
  end

endmodule // ssc_ramp

`default_nettype wire

/* File: ssc_core_sva.sv */
// Purpose: Port-level checker for ssc_core
// Assumes: One clock; synchronous active-high reset
// Notes:   Start checks are taken from idle only
`timescale 1ns/1ps
`default_nettype none
module ssc_core_sva #(parameter W = 32) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // Commands and settings
  input wire logic         servo_on,
  input wire logic         sync_run_request,
  input wire logic         superimposed_cmd,
  input wire logic         gear_reload_request,
  input wire logic         comm_reset,
  input wire logic [W-1:0] sync_accel_time,
  input wire logic [W-1:0] sync_decel_time,
  input wire logic [W-1:0] superimposed_feed_speed,
  // Status
  input wire logic         sync_fault_flag,
  input wire logic         superimposed_fault_flag,
  input wire logic         sync_running,
  input wire logic [W-1:0] motor_speed
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Idle with servo on; a stale fault means the request was not taken
  wire idle_on = servo_on && !sync_running && !sync_fault_flag;
  AST_NO_SERVO: assert property (!servo_on && !sync_running |=> !sync_running)
    else $error("sync started without servo on");
  AST_TC_LIMIT: assert property ($rose(sync_run_request) && idle_on &&
    (sync_accel_time > 32'h4e20 || sync_decel_time > 32'h4e20)
    |=> sync_fault_flag && !sync_running) else $error("long time constant not refused");
  AST_RELOAD: assert property ($rose(sync_run_request) && idle_on &&
    gear_reload_request |=> sync_fault_flag) else $error("start during reload not refused");
  AST_COMM: assert property (sync_running && sync_run_request && comm_reset
    |=> sync_fault_flag) else $error("comm reset in run gave no fault");
  AST_HOLD: assert property (sync_fault_flag && sync_run_request |=> sync_fault_flag)
    else $error("fault flag dropped while request high");
  AST_SUP_OFF: assert property ($rose(superimposed_cmd) && !sync_run_request
    |-> ##[1:3] superimposed_fault_flag) else $error("command without request not flagged");
  AST_SUP_ZERO: assert property ($rose(sync_run_request) && idle_on &&
    superimposed_cmd && superimposed_feed_speed == 32'h0 |-> ##[1:3] superimposed_fault_flag)
    else $error("zero feed speed not flagged");
  AST_RAMP: assert property ((sync_running && !sync_run_request)[*3]
    |-> motor_speed <= $past(motor_speed)) else $error("speed rose during stop");
endmodule // ssc_core_sva
bind ssc_core ssc_core_sva #(.W(W)) u_sva (.clk, .reset, .servo_on, .sync_run_request,
  .superimposed_cmd, .gear_reload_request, .comm_reset, .sync_accel_time, .sync_decel_time,
  .superimposed_feed_speed, .sync_fault_flag, .superimposed_fault_flag, .sync_running,
  .motor_speed);
`default_nettype wire

/* File: ssc_ctrl_model.sv */
// Purpose: Controller side of the gear reload handshake
// Assumes: go is a one-cycle pulse from the bench
// Notes:   Request is a pulse; busy stays up until the device answers
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Bench trigger and device answer
  input  wire logic reload_go,
  input  wire logic gear_reload_done,
  // Command and progress
  output var  logic gear_reload_request,
  output var  logic reload_busy
);
  // A pulse avoids a held level being taken twice; new gear waits for done
  always @(posedge clk) begin
    if (reset) begin
      gear_reload_request <= 1'h0;
      reload_busy <= 1'h0;
    end else begin
      gear_reload_request <= reload_go;
      if (gear_reload_done)
        reload_busy <= 1'h0;
      else if (reload_go)
        reload_busy <= 1'h1;
    end
  end
endmodule // ssc_ctrl_model
`default_nettype wire

/* File: ssc_core_tb_top.sv */
// Purpose: Self-checking bench for ssc_core
// Assumes: MS_CYCLES shortened to 10
// Notes:   Drives on rising edges, samples 1 ns after
`timescale 1ns/1ps
`default_nettype none
module ssc_core_tb_top;
  localparam W = 32;
  logic clk = 1'h0, reset = 1'h1, servo_on = 1'h0, sync_run_request = 1'h0;
  logic superimposed_cmd = 1'h0, comm_reset = 1'h0, reload_go = 1'h0;
  logic link_lost = 1'h0, alarm = 1'h0;
  logic fwd_ok = 1'h1, rev_ok = 1'h1;
  logic [W-1:0] sup_acc = 32'h64;
  wire warn, synced;
  logic [W-1:0] gear_num = 32'h1, gear_den = 32'h1, acc = 32'h4e20, dec = 32'h4e20;
  logic [W-1:0] feed = 32'h5, encoder_pos = 32'h1234;
  wire gear_reload_request, gear_reload_done, reload_busy, sync_fault_flag;
  wire superimposed_fault_flag, sync_running, superimposed_busy;
  wire [W-1:0] home_pos_q, motor_speed;
  int err_count = 0, checks = 0, cyc = 0;
  // Short millisecond so ramps finish in tens of cycles
  ssc_core #(.MS_CYCLES(10)) dut (.clk, .reset, .servo_on, .sync_run_request,
    .superimposed_cmd, .gear_reload_request, .comm_reset, .link_lost, .alarm,
    .forward_travel_limit(fwd_ok), .reverse_travel_limit(rev_ok), .gear_num, .gear_den,
    .sync_accel_time(acc), .sync_decel_time(dec), .superimposed_accel_time(sup_acc),
    .superimposed_decel_time(32'h64), .superimposed_feed_speed(feed),
    .superimposed_feed_length(32'h20), .speed_limit(32'h989680), .encoder_speed(32'h3e8),
    .encoder_pos, .gear_reload_done, .sync_fault_flag, .superimposed_fault_flag,
    .positioning_limit_warning(warn), .sync_running, .synchronized(synced),
    .superimposed_busy,
    .home_pos_q, .motor_speed);
  ssc_ctrl_model ctrl (.clk, .reset, .reload_go, .gear_reload_done, .gear_reload_request,
    .reload_busy);
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step;
    @(posedge clk);
  endtask
  // Bounded wait for the ramp-down to finish
  task automatic to_idle;
    for (int i = 0; i < 300 && (sync_running !== 1'h0 || motor_speed !== 0); i++) look(1);
    chk("run", 0, sync_running);
    chk("speed", 0, motor_speed);
  endtask
  task automatic reload(input logic [W-1:0] n, input logic [W-1:0] d);
    step;
    gear_num <= n;
    gear_den <= d;
    reload_go <= 1'h1;
    step;
    reload_go <= 1'h0;
    look(1);
    for (int i = 0; i < 20 && reload_busy !== 1'h0; i++) look(1);
    chk("reload", 0, reload_busy);
  endtask
  // Start refused with servo off, then a full start and stop
  task automatic t_start;
    step;
    sync_run_request <= 1'h1;
    look(3);
    chk("run", 0, sync_running);
    step;
    sync_run_request <= 1'h0;
    servo_on <= 1'h1;
    step;
    sync_run_request <= 1'h1;
    look(2);
    chk("run", 1, sync_running);
    chk("fault", 0, sync_fault_flag);
    look(60);
    step;
    sync_run_request <= 1'h0;
    to_idle;
  endtask
  // Each bad setting refuses the start; fault holds until request drops
  task automatic t_bad;
    for (int i = 0; i < 4; i++) begin
      step;
      if (i == 0) acc <= 32'h4e21;
      if (i == 1) dec <= 32'h4e21;
      if (i == 2) reload(32'h1771, 32'h1);
      if (i == 3) reload(32'h1, 32'h3e81);
      step;
      sync_run_request <= 1'h1;
      look(2);
      chk("fault", 1, sync_fault_flag);
      chk("run", 0, sync_running);
      look(3);
      chk("fault", 1, sync_fault_flag);
      step;
      sync_run_request <= 1'h0;
      acc <= 32'h4e20;
      dec <= 32'h4e20;
      look(4);
      chk("fault", 0, sync_fault_flag);
    end
    reload(32'h1, 32'h1);
  endtask
  // Request lands with the reload request, then while the reload is pending
  task automatic t_race;
    for (int k = 0; k < 2; k++) begin
      step;
      reload_go <= 1'h1;
      step;
      reload_go <= 1'h0;
      if (k == 1) step;
      sync_run_request <= 1'h1;
      look(3);
      chk("fault", 1, sync_fault_flag);
      step;
      sync_run_request <= 1'h0;
      look(8);
      chk("fault", 0, sync_fault_flag);
    end
  endtask
  // Travel limit on either side: home kept, sync lost, run again once cleared
  task automatic t_limit;
    for (int k = 0; k < 2; k++) begin
      step;
      sync_run_request <= 1'h1;
      look(30);
      chk("sync", 1, synced);
      step;
      if (k == 0) fwd_ok <= 1'h0;
      else rev_ok <= 1'h0;
      look(2);
      chk("sync", 0, synced);
      chk("home", 32'h5678, home_pos_q);
      step;
      fwd_ok <= 1'h1;
      rev_ok <= 1'h1;
      sync_run_request <= 1'h0;
      to_idle;
    end
  endtask
  // Communication reset in run: fault and new home
  task automatic t_comm;
    step;
    sync_run_request <= 1'h1;
    look(20);
    step;
    encoder_pos <= 32'h5678;
    comm_reset <= 1'h1;
    step;
    comm_reset <= 1'h0;
    look(2);
    chk("fault", 1, sync_fault_flag);
    chk("home", 32'h5678, home_pos_q);
    step;
    sync_run_request <= 1'h0;
    to_idle;
  endtask
  // Superimposed errors and warning, then a good move that outlives its command
  task automatic t_sup;
    step;
    superimposed_cmd <= 1'h1;
    sup_acc <= 32'h4e21;
    look(3);
    chk("sup_fault", 1, superimposed_fault_flag);
    chk("warn", 1, warn);
    step;
    superimposed_cmd <= 1'h0;
    sup_acc <= 32'h64;
    feed <= 32'h0;
    look(3);
    chk("sup_fault", 0, superimposed_fault_flag);
    step;
    superimposed_cmd <= 1'h1;
    sync_run_request <= 1'h1;
    look(3);
    chk("warn", 0, warn);
    chk("sup_fault", 1, superimposed_fault_flag);
    chk("sup_busy", 0, superimposed_busy);
    step;
    superimposed_cmd <= 1'h0;
    sync_run_request <= 1'h0;
    feed <= 32'h5;
    to_idle;
    step;
    superimposed_cmd <= 1'h1;
    step;
    sync_run_request <= 1'h1;
    look(3);
    chk("sup_busy", 1, superimposed_busy);
    chk("sup_fault", 0, superimposed_fault_flag);
    step;
    superimposed_cmd <= 1'h0;
    look(3);
    chk("sup_busy", 1, superimposed_busy);
    step;
    alarm <= 1'h1;
    look(2);
    chk("sup_busy", 0, superimposed_busy);
    step;
    alarm <= 1'h0;
    sync_run_request <= 1'h0;
    to_idle;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    look(2);
    chk("home", 32'h1234, home_pos_q);
    t_start;
    t_bad;
    t_race;
    t_comm;
    t_limit;
    t_sup;
    tally_and_finish;
  end
endmodule // ssc_core_tb_top
`default_nettype wire
